// File: verilog/twts_pkg.sv
// Constants, carrier types and the code translator for the terminal write-transfer sequencer.
// Assumes a single 125 MHz system clock; all timing counts derive from it.
// Summary of operation
// - Status first B-clock loads buffer and terminal numbers
// - Status strobe waits for settling after A clears
// - Second status B-clock clears B; wait sync drop
// - Sync-drop A-clock tests write-ready, idles or transfers
// - Transfer A-clock fetches character, triggers both timers
// - A register continuously feeds the selected translator
// - Adapter type selects five-level, ASCII or none
// - Both timers running sends host character strobe
// - Transfer B-clock needs A full, timed, write-ready
// - B loaded by a transfer move drives write request to terminal
// - Terminal strobe B-clock moves next character onward
// - Group mark B-clock sets step 1, then 3
// - Phase 2 step 3 write-ready loss ends operation
package twts_pkg;

  localparam int CLK_PERIOD_NS = 8;
  localparam int A_DELAY_NS = 4000;
  localparam int B_DELAY_NS = 4000;
  localparam int SETTLE_NS = 500;
  localparam int STATUS_GAP_NS = 7000;
  // Least times, rounded up to whole cycles
  localparam int A_DELAY_CYC = (A_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int B_DELAY_CYC = (B_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STATUS_GAP_CYC = (STATUS_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W = 10;

  localparam int CHAR_W = 6;
  localparam int ENC_W = 8;
  localparam int BUF_NUM_W = 4;
  localparam int TERM_NUM_W = 2;
  localparam int ZONE_LO_POS = 4;
  localparam int ZONE_HI_POS = 5;

  // Phase register values
  localparam logic [2:0] PHASE_IDLE = 3'h0;
  localparam logic [2:0] PHASE_TRANSFER = 3'h2;
  localparam logic [2:0] PHASE_STATUS = 3'h6;
  // Step register values
  localparam logic [1:0] STEP_RUN = 2'h0;
  localparam logic [1:0] STEP_MARK = 2'h1;
  localparam logic [1:0] STEP_EXIT = 2'h3;
  // Adapter-type register values
  localparam logic [1:0] XLATE_FIVE = 2'h0;
  localparam logic [1:0] XLATE_ASCII = 2'h1;
  localparam logic [1:0] XLATE_NONE = 2'h2;

  localparam logic [CHAR_W-1:0] GROUP_MARK = 6'h3f;
  localparam logic [ENC_W-1:0] ASCII_BASE = 8'h20;

  typedef struct packed {
    logic host_sync;
    logic write_request;
    logic [CHAR_W-1:0] host_data;
    logic term_strobe;
    logic term_write_ready;
  } twts_pins_type;

  typedef struct packed {
    logic [BUF_NUM_W-1:0] buffer_num;
    logic [TERM_NUM_W-1:0] terminal_num;
    logic write_ready_status;
    logic [1:0] adapter_type;
  } twts_status_type;

  // Host code to line code, per adapter type
  function automatic logic [ENC_W-1:0] twts_translate(input logic [CHAR_W-1:0] ch,
                                                      input logic [1:0] kind);
    logic [ENC_W-1:0] wide;
    wide = {2'h0, ch};
    unique case (kind)
      XLATE_FIVE: twts_translate = {3'h0, ch[4:0]};
      XLATE_ASCII: twts_translate = ASCII_BASE + wide;
      default: twts_translate = wide;
    endcase
  endfunction

endpackage

// File: verilog/twts_sequencer.sv
// Write-transfer sequencer: status return to the host, then the two-stage
// A/translator/B character stream from host to terminal, ending at a group mark.
// Assumes host and terminal pins are asynchronous to clk_sys and that the
// preceding sync step hands over one status_start pulse with the status fields.
`timescale 1ns/10ps
module twts_sequencer
  import twts_pkg::*;
#(
  parameter int A_DELAY = A_DELAY_CYC,
  parameter int B_DELAY = B_DELAY_CYC,
  parameter int SETTLE = SETTLE_CYC,
  parameter int STATUS_GAP = STATUS_GAP_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Hand-over from the sync step
  input wire logic status_start,
  input wire twts_status_type status_info,
  // Host pins
  input wire logic host_sync_level,
  input wire logic write_request_level,
  input wire logic [CHAR_W-1:0] host_output_lines,
  output logic host_char_strobe,
  output logic [ENC_W-1:0] host_info_lines,
  output logic host_write_ready,
  // Terminal pins
  input wire logic terminal_char_strobe,
  input wire logic write_ready_level,
  output logic [ENC_W-1:0] terminal_entry_lines,
  output logic terminal_write_request,
  // Observation
  output logic busy,
  output logic [2:0] phase_out,
  output logic [1:0] step_out
);

  localparam int PIN_W = $bits(twts_pins_type);

  generate
    if (A_DELAY < 1 || A_DELAY >= 2**TIMER_W || B_DELAY < 1 || B_DELAY >= 2**TIMER_W ||
        SETTLE < 1 || SETTLE >= 2**TIMER_W || STATUS_GAP < 1 || STATUS_GAP >= 2**TIMER_W)
    begin : g_bad_timing
      $error("twts_sequencer: timing count outside timer range");
    end
  endgenerate

  // Pin synchronisers: three stages, a change counts once stages two and three agree
  // A one-cycle flicker never reaches the sequence logic; the cost is up to
  // four cycles of latency on every pin, which the timer counts must absorb
  twts_pins_type pins_raw;
  logic [PIN_W-1:0] sync1;
  logic [PIN_W-1:0] sync2;
  logic [PIN_W-1:0] sync3;
  logic [PIN_W-1:0] pins_filt;
  twts_pins_type pin;
  logic term_strobe_prev;

  assign pins_raw = '{host_sync: host_sync_level, write_request: write_request_level,
                      host_data: host_output_lines, term_strobe: terminal_char_strobe,
                      term_write_ready: write_ready_level};
  assign pin = twts_pins_type'(pins_filt);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      pins_filt <= '0;
    end else begin
      sync1 <= pins_raw;
      sync2 <= sync1;
      sync3 <= sync2;
      pins_filt <= (sync2 & ~(sync2 ^ sync3)) | (pins_filt & (sync2 ^ sync3));
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      term_strobe_prev <= 1'b0;
    end else begin
      term_strobe_prev <= pin.term_strobe;
    end
  end

  // Sequence state and stage registers
  logic [2:0] phase;
  logic [1:0] step;
  logic a_stage_occupied;
  logic b_stage_occupied;
  logic [CHAR_W-1:0] a_reg;
  logic [ENC_W-1:0] b_reg;
  logic [ENC_W-1:0] encoder_lines;
  logic status_write_ready_bit;
  logic [1:0] adapter_type;
  logic [TERM_NUM_W-1:0] terminal_num;
  logic [TIMER_W-1:0] a_delay_timer;
  logic [TIMER_W-1:0] b_delay_timer;
  logic [TIMER_W-1:0] settle_timer;
  logic [TIMER_W-1:0] gap_timer;

  logic a_timer_run;
  logic b_timer_run;
  logic in_status_exit;
  logic in_transfer;
  logic term_edge;
  logic start_ok;
  logic status_b1;
  logic status_b2;
  logic status_a;
  logic fetch_a;
  logic accept_b;
  logic move_b;
  logic mark_b;
  logic end_a;
  logic next_strobe;

  assign a_timer_run = a_delay_timer != '0;
  assign b_timer_run = b_delay_timer != '0;
  assign in_status_exit = phase == PHASE_STATUS && step == STEP_EXIT;
  assign in_transfer = phase == PHASE_TRANSFER;
  // Only the rising edge counts; the terminal holds its strobe for several cycles
  assign term_edge = pin.term_strobe && !term_strobe_prev;
  // A new status hand-over is only taken while idle
  assign start_ok = status_start && phase == PHASE_IDLE;

  // The A register always feeds the translator
  assign encoder_lines = twts_translate(a_reg, adapter_type);

  assign status_b1 = in_status_exit && a_stage_occupied && !a_timer_run &&
                     pin.host_sync && !b_stage_occupied;
  // The gap timer stands in for the least spacing between the two status pulses
  assign status_b2 = in_status_exit && b_stage_occupied && !a_stage_occupied &&
                     gap_timer == '0;
  assign status_a = in_status_exit && !a_stage_occupied && !b_stage_occupied &&
                    !pin.host_sync;
  assign fetch_a = in_transfer && step == STEP_RUN && !a_stage_occupied &&
                   pin.write_request;
  // Terminal strobe means the character in B has been taken
  assign accept_b = in_transfer && b_stage_occupied && term_edge;
  assign move_b = in_transfer && step == STEP_RUN && a_stage_occupied && !a_timer_run &&
                  pin.term_write_ready && (!b_stage_occupied || accept_b);
  assign mark_b = accept_b && step == STEP_MARK;
  assign end_a = in_transfer && step == STEP_EXIT && !pin.term_write_ready;

  // Phase and step registers
  // Start, exit and end are exclusive by phase, so the priority order is safe
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      phase <= PHASE_IDLE;
      step <= STEP_RUN;
    end else if (start_ok) begin
      phase <= PHASE_STATUS;
      step <= STEP_EXIT;
    end else if (status_a) begin
      phase <= status_write_ready_bit ? PHASE_TRANSFER : PHASE_IDLE;
      step <= STEP_RUN;
    end else if (end_a) begin
      phase <= PHASE_IDLE;
      step <= STEP_RUN;
    end else if (mark_b) begin
      step <= STEP_EXIT;
    end else if (move_b && a_reg == GROUP_MARK) begin
      step <= STEP_MARK;
    end
  end

  // Stored status from the hand-over
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      status_write_ready_bit <= 1'b0;
      adapter_type <= XLATE_FIVE;
      terminal_num <= '0;
    end else if (start_ok) begin
      status_write_ready_bit <= status_info.write_ready_status;
      adapter_type <= status_info.adapter_type;
      terminal_num <= status_info.terminal_num;
    end
  end

  // A stage
  // The status hand-over also passes through A, hence a start is refused once busy
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      a_reg <= '0;
      a_stage_occupied <= 1'b0;
    end else if (start_ok) begin
      a_reg <= {2'h0, status_info.buffer_num};
      a_stage_occupied <= 1'b1;
    end else if (fetch_a) begin
      a_reg <= pin.host_data;
      a_stage_occupied <= 1'b1;
    end else if (status_b1 || move_b || end_a) begin
      a_stage_occupied <= 1'b0;
    end
  end

  // B stage
  // A reload on the accepting strobe keeps B occupied without a gap cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      b_reg <= '0;
      b_stage_occupied <= 1'b0;
    end else if (status_b1) begin
      b_reg <= '0;
      b_reg[BUF_NUM_W-1:0] <= a_reg[BUF_NUM_W-1:0];
      b_reg[ZONE_LO_POS] <= terminal_num[0];
      b_reg[ZONE_HI_POS] <= terminal_num[1];
      b_stage_occupied <= 1'b1;
    end else if (move_b) begin
      b_reg <= encoder_lines;
      b_stage_occupied <= 1'b1;
    end else if (status_b2 || accept_b || end_a) begin
      b_stage_occupied <= 1'b0;
    end
  end

  // Delay monostables; a reload while running restarts the period
  // Counts are least times: the pin synchronisers add a few cycles on top
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      a_delay_timer <= '0;
    end else if (start_ok || fetch_a) begin
      a_delay_timer <= TIMER_W'(A_DELAY);
    end else if (a_timer_run) begin
      a_delay_timer <= a_delay_timer - 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      b_delay_timer <= '0;
    end else if (status_b1 || fetch_a) begin
      b_delay_timer <= TIMER_W'(B_DELAY);
    end else if (b_timer_run) begin
      b_delay_timer <= b_delay_timer - 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      settle_timer <= '0;
      gap_timer <= '0;
    end else if (status_b1) begin
      settle_timer <= TIMER_W'(SETTLE);
      gap_timer <= TIMER_W'(STATUS_GAP);
    end else begin
      if (settle_timer != '0) begin
        settle_timer <= settle_timer - 1'b1;
      end
      if (gap_timer != '0) begin
        gap_timer <= gap_timer - 1'b1;
      end
    end
  end

  // Host strobe: the status one waits for the info lines to settle after A clears
  // In status the strobe ends with the B timer, which bounds the host's read window
  always_comb begin
    next_strobe = 1'b0;
    if (phase == PHASE_STATUS) begin
      next_strobe = b_timer_run && !a_stage_occupied && settle_timer == '0;
    end else if (in_transfer) begin
      next_strobe = a_timer_run && b_timer_run;
    end
  end

  // Registered outputs
  // Observation copies lag the sequence state by one cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      host_char_strobe <= 1'b0;
      host_write_ready <= 1'b0;
      busy <= 1'b0;
      phase_out <= PHASE_IDLE;
      step_out <= STEP_RUN;
    end else begin
      host_char_strobe <= next_strobe;
      host_write_ready <= status_write_ready_bit;
      busy <= phase != PHASE_IDLE;
      phase_out <= phase;
      step_out <= step;
    end
  end

  // Both line groups show the B register
  assign host_info_lines = b_reg;
  assign terminal_entry_lines = b_reg;

  // The status word in B is for the host only, so only a transfer move raises
  // the request; a move on the accepting strobe keeps it up without a gap
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      terminal_write_request <= 1'b0;
    end else if (move_b) begin
      terminal_write_request <= 1'b1;
    end else if (accept_b || end_a) begin
      terminal_write_request <= 1'b0;
    end
  end

endmodule // twts_sequencer

// File: dv/twts_checker.sv
// Port assertions for the write-transfer sequencer.
// Assumes bench timer values 8/8/2/12 and a four-cycle terminal strobe.
`timescale 1ns/10ps
module twts_checker
  import twts_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Host side
  input wire logic host_sync_level,
  input wire logic host_char_strobe,
  input wire logic [ENC_W-1:0] host_info_lines,
  // Terminal side
  input wire logic terminal_char_strobe,
  input wire logic write_ready_level,
  input wire logic [ENC_W-1:0] terminal_entry_lines,
  input wire logic terminal_write_request,
  // Observation
  input wire logic [2:0] phase_out,
  input wire logic [1:0] step_out
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Cycles since the terminal strobe was high; B may only be emptied just after one
  logic [3:0] strobe_age;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) strobe_age <= 4'hf;
    else if (terminal_char_strobe) strobe_age <= 4'h0;
    else if (strobe_age != 4'hf) strobe_age <= strobe_age + 4'h1;
  end
  chk_lines_same: assert property (
    terminal_entry_lines == host_info_lines) else $error("entry and info lines differ");
  chk_status_settle: assert property (
    $rose(host_char_strobe) && phase_out == PHASE_STATUS
    |-> host_info_lines[7:6] == 2'h0 && host_info_lines == $past(host_info_lines, 3)
    && !terminal_write_request) else $error("status load or settle wrong");
  chk_hold_req: assert property (
    $fell(terminal_write_request) && phase_out == PHASE_TRANSFER |-> strobe_age < 4'h8)
    else $error("request dropped without strobe");
  chk_no_reload: assert property (
    $changed(terminal_entry_lines) && $past(terminal_write_request)
    && phase_out == PHASE_TRANSFER |-> strobe_age < 4'h8) else $error("full B overwritten");
  chk_exit_order: assert property (
    phase_out == PHASE_TRANSFER && step_out == STEP_EXIT && $past(step_out) != STEP_EXIT
    |-> $past(step_out) == STEP_MARK) else $error("step 3 not after step 1");
  chk_end_idle: assert property (
    (phase_out == PHASE_TRANSFER && step_out == STEP_EXIT && !write_ready_level) [*3]
    |-> ##[1:6] phase_out == PHASE_IDLE) else $error("no end on ready loss");
  chk_sync_exit: assert property (
    (phase_out == PHASE_STATUS && !host_sync_level) [*8] |-> ##[1:40] phase_out != PHASE_STATUS)
    else $error("status not left on sync drop");
  chk_strobe_len: assert property (
    $rose(host_char_strobe) && phase_out == PHASE_TRANSFER
    |-> host_char_strobe [*4] ##[1:8] !host_char_strobe) else $error("strobe length wrong");
endmodule // twts_checker

bind twts_sequencer twts_checker u_chk (.clk_sys(clk_sys), .rst_n(rst_n),
  .host_sync_level(host_sync_level), .host_char_strobe(host_char_strobe),
  .host_info_lines(host_info_lines), .terminal_char_strobe(terminal_char_strobe),
  .write_ready_level(write_ready_level), .terminal_entry_lines(terminal_entry_lines),
  .terminal_write_request(terminal_write_request), .phase_out(phase_out), .step_out(step_out));

// File: dv/twts_far_end.sv
// Behavioural terminal unit on the far side of the sequencer.
// Assumes the bench arms write-ready and names the translated group mark.
`timescale 1ns/10ps
module twts_far_end
  import twts_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Terminal pins
  input wire logic terminal_write_request,
  input wire logic [ENC_W-1:0] terminal_entry_lines,
  output logic terminal_char_strobe,
  output logic write_ready_level,
  // Bench control and report
  input wire logic arm,
  input wire logic slow,
  input wire logic [ENC_W-1:0] mark_code,
  output logic taken,
  output logic [ENC_W-1:0] taken_code
);
  logic [5:0] wait_cnt;
  logic [2:0] hi_cnt;
  logic mark_seen;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      {wait_cnt, hi_cnt, mark_seen, taken, taken_code} <= '0;
      {terminal_char_strobe, write_ready_level} <= 2'h0;
    end else begin
      taken <= 1'b0;
      if (hi_cnt != 3'h0) begin
        hi_cnt <= hi_cnt - 3'h1;
        terminal_char_strobe <= (hi_cnt != 3'h1);
      end else if (terminal_write_request && write_ready_level) begin
        wait_cnt <= wait_cnt + 6'h1;
        if (wait_cnt == (slow ? 6'h28 : 6'h04)) begin
          wait_cnt <= 6'h0;
          hi_cnt <= 3'h4;
          terminal_char_strobe <= 1'b1;
          taken <= 1'b1;
          taken_code <= terminal_entry_lines;
          mark_seen <= (terminal_entry_lines == mark_code);
        end
      end else begin
        wait_cnt <= 6'h0;
      end
      if (arm) write_ready_level <= 1'b1;
      else if (mark_seen && hi_cnt == 3'h0 && !terminal_write_request) begin
        write_ready_level <= 1'b0;
        mark_seen <= 1'b0;
      end
    end
  end
endmodule // twts_far_end

// File: dv/twts_sequencer_tb.sv
// Self-checking bench: status return, streams in every adapter type, not-ready exit.
// Assumes small timer parameters; the far-end model answers for the terminal.
`timescale 1ns/10ps
module twts_sequencer_tb
  import twts_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic status_start = 1'b0;
  twts_status_type status_info = '0;
  logic host_sync_level = 1'b0;
  logic write_request_level = 1'b0;
  logic [CHAR_W-1:0] host_output_lines = '0;
  logic arm = 1'b0;
  logic slow = 1'b0;
  logic [ENC_W-1:0] mark_code = '0;
  logic host_char_strobe, host_write_ready, terminal_char_strobe, write_ready_level;
  logic terminal_write_request, busy, taken;
  logic [ENC_W-1:0] host_info_lines, terminal_entry_lines, taken_code;
  logic [2:0] phase_out;
  logic [1:0] step_out;
  logic [ENC_W-1:0] expq[$];
  logic [31:0] rnd = 32'h1849;
  int mismatches = 0;
  int tests_run = 0;
  always #4 clk_sys = ~clk_sys;
  twts_sequencer #(.A_DELAY(8), .B_DELAY(8), .SETTLE(2), .STATUS_GAP(12)) u_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .status_start(status_start), .status_info(status_info),
    .host_sync_level(host_sync_level), .write_request_level(write_request_level),
    .host_output_lines(host_output_lines), .host_char_strobe(host_char_strobe),
    .host_info_lines(host_info_lines), .host_write_ready(host_write_ready),
    .terminal_char_strobe(terminal_char_strobe), .write_ready_level(write_ready_level),
    .terminal_entry_lines(terminal_entry_lines), .terminal_write_request(terminal_write_request),
    .busy(busy), .phase_out(phase_out), .step_out(step_out));
  twts_far_end u_far (.clk_sys(clk_sys), .rst_n(rst_n), .terminal_write_request(terminal_write_request),
    .terminal_entry_lines(terminal_entry_lines), .terminal_char_strobe(terminal_char_strobe),
    .write_ready_level(write_ready_level), .arm(arm), .slow(slow), .mark_code(mark_code),
    .taken(taken), .taken_code(taken_code));
  function automatic logic [ENC_W-1:0] xl(input logic [CHAR_W-1:0] ch, input logic [1:0] t);
    if (t == 2'h0) return {3'h0, ch[4:0]};
    if (t == 2'h1) return 8'h20 + {2'h0, ch};
    return {2'h0, ch};
  endfunction
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic tick;
    @(posedge clk_sys);
    #1;
  endtask
  task automatic wait_rise;
    int k;
    for (k = 0; k < 3000 && host_char_strobe !== 1'b0; k++) tick;
    for (k = k; k < 3000 && host_char_strobe !== 1'b1; k++) tick;
    if (k >= 3000) begin
      mismatches++;
      end_of_test;
    end
  endtask
  // Codes avoid bit 4 so no data character translates to the group mark's code
  task automatic run(input logic [1:0] t, input logic wr, input logic sl, input int n);
    logic [CHAR_W-1:0] ch[$];
    logic [BUF_NUM_W-1:0] bn;
    logic [TERM_NUM_W-1:0] tn;
    int i;
    int k;
    rnd = lfsr(rnd);
    bn = rnd[3:0];
    tn = rnd[5:4];
    for (i = 1; i < n; i++) begin
      rnd = lfsr(rnd);
      ch.push_back({rnd[5], 1'b0, rnd[3:0]});
    end
    ch.push_back(GROUP_MARK);
    for (i = 0; i < n && wr; i++) expq.push_back(xl(ch[i], t));
    @(posedge clk_sys);
    host_sync_level <= 1'b1;
    slow <= sl;
    arm <= wr;
    mark_code <= xl(GROUP_MARK, t);
    repeat (8) @(posedge clk_sys);
    status_start <= 1'b1;
    status_info <= '{bn, tn, wr, t};
    @(posedge clk_sys);
    status_start <= 1'b0;
    arm <= 1'b0;
    wait_rise;
    check("status info", host_info_lines, {2'h0, tn, bn});
    check("write ready", {7'h0, host_write_ready}, {7'h0, wr});
    @(posedge clk_sys);
    host_sync_level <= 1'b0;
    host_output_lines <= ch[0];
    write_request_level <= wr;
    // A second start while busy must be ignored
    for (i = 1; i < n && wr; i++) begin
      wait_rise;
      @(posedge clk_sys);
      host_output_lines <= ch[i];
      status_start <= (i == 1);
    end
    if (wr) wait_rise;
    @(posedge clk_sys);
    status_start <= 1'b0;
    write_request_level <= 1'b0;
    host_output_lines <= ~GROUP_MARK;
    for (k = 0; k < 3000 && busy !== 1'b0; k++) tick;
    tick;
    check("end state", {k >= 3000, 2'h0, phase_out, step_out}, 8'h00);
    check("codes left", 8'(expq.size()), 8'h00);
    if (k >= 3000) end_of_test;
    $display("test done: type %0d ready %0d", t, wr);
  endtask
  always @(posedge clk_sys) begin
    if (taken === 1'b1) check("line code", taken_code, expq.size() > 0 ? expq.pop_front() : 8'hxx);
  end
  initial begin
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    tick;
    check("reset", {host_char_strobe, terminal_write_request, busy, phase_out, step_out}, 8'h00);
    run(XLATE_FIVE, 1'b1, 1'b0, 6);
    run(XLATE_ASCII, 1'b1, 1'b1, 4);
    run(XLATE_NONE, 1'b1, 1'b0, 6);
    run(2'h3, 1'b1, 1'b0, 3);
    run(XLATE_ASCII, 1'b0, 1'b0, 1);
    end_of_test;
  end
endmodule // twts_sequencer_tb
